/* File: logic/scpm_top.sv */
// Switch control pin mux: parallel or serial control of four channels
`include "scpm_defines.svh"

module scpm_top (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic mode_serial_i,
    input  wire logic ext_drive_enable_i,
    input  wire logic ctrl_in_one_i,
    input  wire logic ctrl_in_two_i,
    input  wire logic ctrl_in_three_i,
    input  wire logic ctrl_in_four_i,
    output logic      ctrl_in_four_o,
    output logic      ctrl_in_four_oe_o,
    output logic      gate_1a_o,
    output logic      gate_2a_o,
    output logic      gate_2b_o,
    output logic      gate_1b_o,
    output logic      osc_clk_o,
    output logic      boost_enable_o
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [5:0] sync_a;
    logic [5:0] sync_b;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_a <= 6'h00;
            sync_b <= 6'h00;
        end else begin
            sync_a <= {ext_drive_enable_i, mode_serial_i, ctrl_in_four_i,
                       ctrl_in_three_i, ctrl_in_two_i, ctrl_in_one_i};
            sync_b <= sync_a;
        end
    end

    wire pin_one   = sync_b[0];
    wire pin_two   = sync_b[1];
    wire pin_three = sync_b[2];
    wire pin_four  = sync_b[3];
    wire serial    = sync_b[4];
    wire ext_drive = sync_b[5];

    // ----------------------------------------
    // Serial port
    // ----------------------------------------
    logic [3:0] ser_load;
    logic       ser_load_valid;
    logic       ser_sdo;
    logic       ser_sdo_oe;
    logic [3:0] ch_state;

    scpm_serial u_serial (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .enable_i        (serial),
        .sdi_i           (pin_one),
        .cs_n_i          (pin_two),
        .sclk_i          (pin_three),
        .ch_state_i      (ch_state),
        .ch_load_o       (ser_load),
        .ch_load_valid_o (ser_load_valid),
        .sdo_o           (ser_sdo),
        .sdo_oe_o        (ser_sdo_oe)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_in_four_o    <= 1'b0;
            ctrl_in_four_oe_o <= 1'b0;
        end else begin
            ctrl_in_four_o    <= ser_sdo;
            ctrl_in_four_oe_o <= serial && ser_sdo_oe;
        end
    end

    // ----------------------------------------
    // Channel gates
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ch_state <= `SCPM_CH_RESET;
        end else if (!serial) begin
            ch_state <= {pin_one, pin_two, pin_three, pin_four};
        end else if (ser_load_valid) begin
            ch_state <= ser_load;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_1a_o <= 1'b0;
            gate_2a_o <= 1'b0;
            gate_2b_o <= 1'b0;
            gate_1b_o <= 1'b0;
        end else begin
            gate_1a_o <= ch_state[3];
            gate_2a_o <= ch_state[2];
            gate_2b_o <= ch_state[1];
            gate_1b_o <= ch_state[0];
        end
    end

    // ----------------------------------------
    // Internal oscillator and boost
    // ----------------------------------------
    logic [7:0] osc_cnt;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_cnt        <= 8'h00;
            osc_clk_o      <= 1'b0;
            boost_enable_o <= 1'b0;
        end else begin
            boost_enable_o <= !ext_drive;
            if (ext_drive) begin
                osc_cnt   <= 8'h00;
                osc_clk_o <= 1'b0;
            end else if (osc_cnt == 8'(`SCPM_OSC_PERIOD_CYC - 1)) begin
                // Five clocks a period, high for two of them
                osc_cnt   <= 8'h00;
                osc_clk_o <= 1'b1;
            end else begin
                osc_cnt <= osc_cnt + 8'h01;
                if (osc_cnt == 8'(`SCPM_OSC_HALF_CYC - 1)) begin
                    osc_clk_o <= 1'b0;
                end
            end
        end
    end

endmodule

/* File: pkg/scpm_defines.svh */
// Constants for the switch control pin mux
`ifndef SCPM_DEFINES_SVH
`define SCPM_DEFINES_SVH

`define SCPM_CLK_HZ          50000000
`define SCPM_OSC_HZ          10000000
`define SCPM_OSC_PERIOD_CYC  (`SCPM_CLK_HZ / `SCPM_OSC_HZ)
`define SCPM_OSC_HALF_CYC    (`SCPM_OSC_PERIOD_CYC / 2)
`define SCPM_FRAME_BITS      16
`define SCPM_CNT_W           5
`define SCPM_CH_RESET        4'h0

`endif

/* File: pkg/scpm_pkg.sv */
// Types for the switch control pin mux
package scpm_pkg;
    typedef enum logic [1:0] {
        SCPM_IDLE,
        SCPM_SHIFT,
        SCPM_DONE
    } scpm_state_t;
endpackage

/* File: logic/scpm_serial.sv */
// Serial port engine: samples on clock rise, shifts out on clock fall
`include "scpm_defines.svh"

module scpm_serial (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       enable_i,
    input  wire logic       sdi_i,
    input  wire logic       cs_n_i,
    input  wire logic       sclk_i,
    input  wire logic [3:0] ch_state_i,
    output logic      [3:0] ch_load_o,
    output logic            ch_load_valid_o,
    output logic            sdo_o,
    output logic            sdo_oe_o
);

    // ----------------------------------------
    // Edge detection and frame state
    // ----------------------------------------
    logic                     sclk_d;
    logic                     cs_d;
    logic [15:0]              shift_in;
    logic [15:0]              shift_out;
    logic [`SCPM_CNT_W-1:0]   bit_cnt;
    scpm_pkg::scpm_state_t    state;

    wire active   = enable_i && !cs_n_i;
    wire sclk_ris = sclk_i && !sclk_d;
    wire sclk_fal = !sclk_i && sclk_d;
    wire cs_fall  = !cs_n_i && cs_d;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d <= 1'b0;
            cs_d   <= 1'b1;
        end else begin
            sclk_d <= sclk_i;
            cs_d   <= cs_n_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state           <= scpm_pkg::SCPM_IDLE;
            bit_cnt         <= '0;
            shift_in        <= 16'h0000;
            shift_out       <= 16'h0000;
            ch_load_o       <= `SCPM_CH_RESET;
            ch_load_valid_o <= 1'b0;
        end else begin
            ch_load_valid_o <= 1'b0;
            if (!active) begin
                state   <= scpm_pkg::SCPM_IDLE;
                bit_cnt <= '0;
            end else begin
                case (state)
                    scpm_pkg::SCPM_IDLE: begin
                        if (cs_fall) begin
                            state     <= scpm_pkg::SCPM_SHIFT;
                            bit_cnt   <= '0;
                            shift_out <= {12'h000, ch_state_i};
                        end
                    end
                    scpm_pkg::SCPM_SHIFT: begin
                        if (sclk_ris) begin
                            shift_in <= {shift_in[14:0], sdi_i};
                            bit_cnt  <= bit_cnt + 1'b1;
                            if (bit_cnt == `SCPM_CNT_W'(`SCPM_FRAME_BITS - 1)) begin
                                state           <= scpm_pkg::SCPM_DONE;
                                ch_load_o       <= {shift_in[2:0], sdi_i};
                                ch_load_valid_o <= 1'b1;
                            end
                        end
                        if (sclk_fal && bit_cnt != '0) begin
                            shift_out <= {shift_out[14:0], 1'b0};
                        end
                    end
                    scpm_pkg::SCPM_DONE: begin
                        state <= scpm_pkg::SCPM_DONE;
                    end
                    default: begin
                        state <= scpm_pkg::SCPM_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Data output driver
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_o    <= 1'b0;
            sdo_oe_o <= 1'b0;
        end else begin
            sdo_oe_o <= active && state != scpm_pkg::SCPM_IDLE;
            sdo_o    <= shift_out[15];
        end
    end

endmodule

/* File: testbench/scpm_asserts.sv */
// Checker for the switch control pin mux
module scpm_asserts (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic mode_serial_i,
    input wire logic ext_drive_enable_i,
    input wire logic ctrl_in_one_i,
    input wire logic ctrl_in_two_i,
    input wire logic ctrl_in_four_i,
    input wire logic ctrl_in_four_oe_o,
    input wire logic gate_1a_o,
    input wire logic gate_1b_o,
    input wire logic osc_clk_o,
    input wire logic boost_enable_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_par_1a; (!mode_serial_i && $stable(ctrl_in_one_i))[*7] |-> gate_1a_o == ctrl_in_one_i; endproperty
    property p_par_1b; (!mode_serial_i && $stable(ctrl_in_four_i))[*7] |-> gate_1b_o == ctrl_in_four_i; endproperty
    property p_oe_par; !mode_serial_i[*4] |-> !ctrl_in_four_oe_o; endproperty
    property p_oe_idle; (mode_serial_i && ctrl_in_two_i)[*5] |-> !ctrl_in_four_oe_o; endproperty
    property p_oe_on;
        mode_serial_i[*6] ##1 (mode_serial_i && $fell(ctrl_in_two_i)) |-> ##5 ctrl_in_four_oe_o;
    endproperty
    property p_boost_on; !ext_drive_enable_i[*5] |-> boost_enable_o; endproperty
    property p_boost_off; ext_drive_enable_i[*4] |-> !boost_enable_o && !osc_clk_o; endproperty
    property p_osc; !ext_drive_enable_i[*6] |-> ##[1:3] $changed(osc_clk_o); endproperty
    a_par_1a: assert property (p_par_1a) else $error("gate 1a does not follow pin one");
    a_par_1b: assert property (p_par_1b) else $error("gate 1b does not follow pin four");
    a_oe_par: assert property (p_oe_par) else $error("pin four driven in parallel mode");
    a_oe_idle: assert property (p_oe_idle) else $error("pin four driven while deselected");
    a_oe_on: assert property (p_oe_on) else $error("pin four not driven in frame");
    a_boost_on: assert property (p_boost_on) else $error("boost off with drive enable low");
    a_boost_off: assert property (p_boost_off) else $error("boost or oscillator running");
    a_osc: assert property (p_osc) else $error("oscillator stalled");
    c_both: cover property (gate_1a_o && gate_1b_o);
    c_oe: cover property (ctrl_in_four_oe_o);
    c_ext: cover property (!boost_enable_o);
endmodule

bind scpm_top scpm_asserts u_chk (
    .clk_i              (clk_i),
    .rst_n_i            (rst_n_i),
    .mode_serial_i      (mode_serial_i),
    .ext_drive_enable_i (ext_drive_enable_i),
    .ctrl_in_one_i      (ctrl_in_one_i),
    .ctrl_in_two_i      (ctrl_in_two_i),
    .ctrl_in_four_i     (ctrl_in_four_i),
    .ctrl_in_four_oe_o  (ctrl_in_four_oe_o),
    .gate_1a_o          (gate_1a_o),
    .gate_1b_o          (gate_1b_o),
    .osc_clk_o          (osc_clk_o),
    .boost_enable_o     (boost_enable_o)
);

/* File: testbench/scpm_host.sv */
// Host model driving the shared control pins
module scpm_host (
    input  wire logic clk_i,
    input  wire logic pin_four_i,
    output logic      ctrl_one_o,
    output logic      ctrl_two_o,
    output logic      ctrl_three_o,
    output logic      ctrl_four_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {ctrl_one_o, ctrl_two_o, ctrl_three_o, ctrl_four_o} = 4'h0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic par(input logic [3:0] v);
        @(posedge clk_i);
        {ctrl_one_o, ctrl_two_o, ctrl_three_o, ctrl_four_o} <= v;
    endtask
    // Clock idles low between frames
    task automatic spi(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge clk_i);
        ctrl_two_o <= 1'b0;
        ctrl_four_o <= ~pin_four_i;
        for (int i = 15; i >= 0; i--) begin
            ctrl_one_o <= tx[i];
            idle(4);
            ctrl_three_o <= 1'b1;
            idle(2);
            rx[i] = pin_four_i;
            idle(2);
            ctrl_three_o <= 1'b0;
        end
        idle(4);
        ctrl_two_o <= 1'b1;
        idle(8);
    endtask
endmodule

/* File: testbench/scpm_top_test.sv */
// Self-checking bench for the switch control pin mux
module scpm_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic mode = 1'b0;
    logic ext = 1'b0;
    logic one, two, three, h4, d4, oe, g1a, g2a, g2b, g1b, osc, boost;
    logic [15:0] rx;
    logic [3:0] e;
    int err_count = 0;
    int checked = 0;
    int osc_rises = 0;
    logic osc_last;
    wire logic pin4 = oe ? d4 : h4;
    always #10 clk_i = ~clk_i;
    scpm_host u_host (.clk_i(clk_i), .pin_four_i(pin4), .ctrl_one_o(one), .ctrl_two_o(two),
        .ctrl_three_o(three), .ctrl_four_o(h4));
    scpm_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_serial_i(mode), .ext_drive_enable_i(ext),
        .ctrl_in_one_i(one), .ctrl_in_two_i(two), .ctrl_in_three_i(three), .ctrl_in_four_i(pin4),
        .ctrl_in_four_o(d4), .ctrl_in_four_oe_o(oe), .gate_1a_o(g1a), .gate_2a_o(g2a),
        .gate_2b_o(g2b), .gate_1b_o(g1b), .osc_clk_o(osc), .boost_enable_o(boost));
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
        checked++;
        if (s !== x) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        err_count++;
        summarize();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        u_host.idle(6);
        rst_n_i <= 1'b1;
        u_host.idle(4);
        for (int v = 0; v < 17; v++) begin
            e = (v == 16) ? 4'h4 : v[3:0];
            u_host.par(e);
            u_host.idle(8);
            chk("gates", {12'h0, e}, {12'h0, g1a, g2a, g2b, g1b});
            chk("oe", 16'h0, {15'h0, oe});
        end
        $display("parallel test done");
        mode <= 1'b1;
        u_host.idle(6);
        u_host.spi(16'hfa5a, rx);
        chk("sdo", 16'h0004, rx);
        chk("gates", 16'h000a, {12'h0, g1a, g2a, g2b, g1b});
        u_host.spi(16'h0005, rx);
        chk("sdo", 16'h000a, rx);
        u_host.par(4'h6);
        u_host.idle(8);
        u_host.par(4'h4);
        u_host.idle(8);
        chk("gates", 16'h0005, {12'h0, g1a, g2a, g2b, g1b});
        $display("serial test done");
        ext <= 1'b1;
        u_host.idle(5);
        chk("boost", 16'h0, {14'h0, boost, osc});
        u_host.spi(16'h0003, rx);
        chk("sdo", 16'h0005, rx);
        chk("gates", 16'h0003, {12'h0, g1a, g2a, g2b, g1b});
        mode <= 1'b0;
        u_host.par(4'h9);
        u_host.idle(8);
        chk("gates", 16'h0009, {12'h0, g1a, g2a, g2b, g1b});
        ext <= 1'b0;
        u_host.idle(6);
        chk("boost", 16'h0001, {15'h0, boost});
        for (int k = 0; k < 50; k++) begin
            osc_last = osc;
            u_host.idle(1);
            if (osc && !osc_last) begin
                osc_rises++;
            end
        end
        chk("osc rises", 16'h000a, 16'(osc_rises));
        $display("drive test done");
        summarize();
    end
endmodule
